// File: verilog/wcd_top.sv
// Purpose: decode the watchdog configuration word into watchdog settings
// Assumes: register port with one-cycle read latency; sleep_i on clk_i
// Notes: control register period and window load from the word once it is captured after reset
// Notes on behaviour
// - clock select is bits 13-11, window 10-8, enable 6-5, period 4-0.
// - clock code 111 takes the runtime clock select bits; 110 to 010 are reserved.
// - clock code 001 picks the 31.25 kHz medium oscillator and is the default.
// - clock code 000 picks the 31.00 kHz low oscillator.
// - window codes 111 and 110 load window 111, fully open, software may change it freely.
// - window codes 101 to 000 load their own value, from 25/75 to 87.5/12.5 percent.
// - window codes 101 to 000 lock the window and require keyed service.
// - enable code 11 runs always, sleep included, ignoring the override bit.
// - enable code 10 runs while executing and stops in sleep.
// - enable code 01 follows the override bit; code 00 never runs.
// - bit 7 of the word is unimplemented and reads as one.
// - a blank word gives clock 001, window 111, enable 11, period all ones.
`timescale 1ns/10ps
module wcd_top
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic [wcd_pkg::CFG_W-1:0] cfg_word_i,
    input wire logic sleep_i,
    input wire logic [wcd_pkg::ADDR_W-1:0] addr_i,
    input wire logic [wcd_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [wcd_pkg::DATA_W-1:0] rdata_o,
    output logic wd_run_o,
    output logic [2:0] wd_clk_sel_o,
    output logic [2:0] wd_window_o,
    output logic [4:0] wd_period_o,
    output logic wd_keyed_req_o,
    output logic wd_window_sw_o,
    output logic cfg_ready_o
);
    import wcd_pkg::*;

    wcd_cfg_if cfg ();

    wcd_cfg_load u_load (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .cfg_word_i(cfg_word_i),
        .cfg(cfg.src)
    );

    // =========================================================
    // control register state
    logic sen_r;
    logic sen_nxt;
    logic [4:0] per_r;
    logic [4:0] per_nxt;
    logic [2:0] cs_r;
    logic [2:0] cs_nxt;
    logic [2:0] win_r;
    logic [2:0] win_nxt;
    logic loaded_r;
    logic loaded_nxt;
    logic load_now;
    logic win_sw_ok;
    logic [2:0] win_por;

    // window value at power-on and software permission
    always_comb
    begin
        win_sw_ok = (cfg.ws == WS_OPEN) || (cfg.ws == WS_OPEN_ALT);
        win_por = win_sw_ok ? WS_OPEN : cfg.ws;
    end

    assign load_now = cfg.valid && !loaded_r;

    always_comb
    begin
        sen_nxt = sen_r;
        per_nxt = per_r;
        cs_nxt = cs_r;
        win_nxt = win_r;
        loaded_nxt = loaded_r;
        if (load_now)
        begin
            per_nxt = cfg.ps;
            win_nxt = win_por;
            loaded_nxt = 1'b1;
        end
        else if (wr_i && (addr_i == OFF_CTRL))
        begin
            sen_nxt = wdata_i[CTL_SEN_BIT];
            per_nxt = wdata_i[CTL_PER_LSB+:5];
            cs_nxt = wdata_i[CTL_CS_LSB+:3];
            if (win_sw_ok)
            begin
                win_nxt = wdata_i[CTL_WIN_LSB+:3];
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sen_r <= CTL_SEN_RST;
            per_r <= CTL_PER_RST;
            cs_r <= CTL_CS_RST;
            win_r <= CTL_WIN_RST;
            loaded_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            sen_r <= sen_nxt;
            per_r <= per_nxt;
            cs_r <= cs_nxt;
            win_r <= win_nxt;
            loaded_r <= loaded_nxt;
        end
    end

    // =========================================================
    // decoded watchdog settings
    logic run_nxt;
    logic [2:0] clk_nxt;
    logic cs_reserved;
    logic key_nxt;

    always_comb
    begin
        cs_reserved = 1'b0;
        key_nxt = !win_sw_ok;
        case (cfg.cs)
            CS_RUNTIME: clk_nxt = cs_r;
            CS_MEDIUM_OSC: clk_nxt = CS_MEDIUM_OSC;
            CS_LOW_OSC: clk_nxt = CS_LOW_OSC;
            default:
            begin
                // reserved codes fall back to the default source
                clk_nxt = CS_MEDIUM_OSC;
                cs_reserved = 1'b1;
            end
        endcase
        case (cfg.en)
            EN_ALWAYS: run_nxt = 1'b1;
            EN_RUN_ONLY: run_nxt = !sleep_i;
            EN_SOFT: run_nxt = sen_r;
            EN_OFF: run_nxt = 1'b0;
            default: run_nxt = 1'b0;
        endcase
        if (!cfg.valid)
        begin
            run_nxt = 1'b0;
            key_nxt = 1'b1;
        end
    end

    logic csres_r;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wd_run_o <= 1'b0;
            wd_clk_sel_o <= CS_MEDIUM_OSC;
            wd_window_o <= CTL_WIN_RST;
            wd_period_o <= CTL_PER_RST;
            wd_keyed_req_o <= 1'b1;
            wd_window_sw_o <= 1'b0;
            cfg_ready_o <= 1'b0;
            csres_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            wd_run_o <= run_nxt;
            wd_clk_sel_o <= clk_nxt;
            wd_window_o <= win_r;
            wd_period_o <= per_r;
            wd_keyed_req_o <= key_nxt;
            wd_window_sw_o <= cfg.valid && win_sw_ok;
            cfg_ready_o <= loaded_r;
            csres_r <= cfg.valid && cs_reserved;
        end
    end

    // =========================================================
    // register read port
    logic [DATA_W-1:0] rd_nxt;
    logic [DATA_W-1:0] ctrl_view;
    logic [DATA_W-1:0] stat_view;

    always_comb
    begin
        ctrl_view = '0;
        ctrl_view[CTL_SEN_BIT] = sen_r;
        ctrl_view[CTL_PER_LSB+:5] = per_r;
        ctrl_view[CTL_CS_LSB+:3] = cs_r;
        ctrl_view[CTL_WIN_LSB+:3] = win_r;
        stat_view = '0;
        stat_view[ST_RUN_BIT] = wd_run_o;
        stat_view[ST_CLK_LSB+:3] = wd_clk_sel_o;
        stat_view[ST_KEY_BIT] = wd_keyed_req_o;
        stat_view[ST_WSW_BIT] = wd_window_sw_o;
        stat_view[ST_RDY_BIT] = cfg_ready_o;
        stat_view[ST_CSRES_BIT] = csres_r;
        rd_nxt = '0;
        if (rd_i)
        begin
            case (addr_i)
                OFF_CTRL: rd_nxt = ctrl_view;
                OFF_CFG: rd_nxt = {2'h0, cfg.word};
                OFF_STAT: rd_nxt = stat_view;
                default: rd_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_o <= '0;
        end
        else if (clk_en_i)
        begin
            rdata_o <= rd_nxt;
        end
    end

    // =========================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // =========================================================
    // enable policy
    a_always_runs: assert property (clk_en_i && cfg.valid && cfg.en == EN_ALWAYS
        |=> wd_run_o)
        else $error("watchdog stopped under always-on policy");
    a_always_sleep: assert property (clk_en_i && cfg.valid && sleep_i
        && cfg.en == EN_ALWAYS |=> wd_run_o)
        else $error("watchdog stopped in sleep under always-on policy");
    a_sleep_stops: assert property (clk_en_i && cfg.valid && cfg.en == EN_RUN_ONLY
        |=> wd_run_o == !$past(sleep_i))
        else $error("run-only policy does not follow sleep");
    a_soft_follows: assert property (clk_en_i && cfg.valid && cfg.en == EN_SOFT
        |=> wd_run_o == $past(sen_r))
        else $error("soft policy does not follow override bit");
    a_sen_write: assert property (clk_en_i && loaded_r && wr_i && addr_i == OFF_CTRL
        |=> sen_r == $past(wdata_i[CTL_SEN_BIT]))
        else $error("override bit write lost");
    a_off_never: assert property (cfg.en == EN_OFF |-> ##1 !wd_run_o)
        else $error("watchdog ran while disabled");
    a_off_ignores_sen: assert property (clk_en_i && cfg.en == EN_OFF && sen_r
        |=> !wd_run_o)
        else $error("override bit woke a disabled watchdog");

    // =========================================================
    // clock select
    a_runtime_clock: assert property (clk_en_i && cfg.valid && cfg.cs == CS_RUNTIME
        |=> wd_clk_sel_o == $past(cs_r))
        else $error("runtime clock select not honoured");
    a_runtime_write: assert property (clk_en_i && loaded_r && wr_i && addr_i == OFF_CTRL
        |=> cs_r == $past(wdata_i[CTL_CS_LSB+:3]))
        else $error("runtime clock select write lost");
    a_reserved_clock: assert property (clk_en_i && cfg.valid && cfg.cs != CS_RUNTIME
        && cfg.cs != CS_MEDIUM_OSC && cfg.cs != CS_LOW_OSC
        |=> wd_clk_sel_o == CS_MEDIUM_OSC && csres_r)
        else $error("reserved clock code not handled");
    a_csres_clear: assert property (clk_en_i && !cs_reserved |=> !csres_r)
        else $error("reserved clock flag set for a valid code");
    a_medium_clock: assert property (clk_en_i && cfg.cs == CS_MEDIUM_OSC
        |=> wd_clk_sel_o == CS_MEDIUM_OSC)
        else $error("medium oscillator not selected");
    a_low_clock: assert property (clk_en_i && cfg.cs == CS_LOW_OSC
        |=> wd_clk_sel_o == CS_LOW_OSC)
        else $error("low oscillator not selected");

    // =========================================================
    // window and keyed access
    a_window_load: assert property (clk_en_i && load_now
        |=> win_r == $past(win_por) ##1 !$past(clk_en_i) || wd_window_o == $past(win_r))
        else $error("power-on window not loaded");
    a_ws_open_alt: assert property (clk_en_i && load_now && cfg.ws == WS_OPEN_ALT
        |=> win_r == WS_OPEN)
        else $error("alternate open code did not load a fully open window");
    a_keyed_window: assert property (clk_en_i && load_now && cfg.ws < WS_OPEN_ALT
        |=> win_r == $past(cfg.ws))
        else $error("closed window code not loaded as is");
    a_window_locked: assert property (clk_en_i && loaded_r && cfg.ws < WS_OPEN_ALT
        |=> $stable(win_r))
        else $error("locked window changed");
    a_open_write: assert property (clk_en_i && loaded_r && win_sw_ok && wr_i
        && addr_i == OFF_CTRL |=> win_r == $past(wdata_i[CTL_WIN_LSB+:3]))
        else $error("open window write lost");
    a_keyed_access: assert property (clk_en_i && cfg.valid
        |=> wd_keyed_req_o == ($past(cfg.ws) < WS_OPEN_ALT))
        else $error("keyed access flag wrong");
    a_keyed_before_load: assert property (clk_en_i && !cfg.valid |=> wd_keyed_req_o)
        else $error("keyed access not required before load");
    a_window_sw_flag: assert property (clk_en_i && cfg.valid
        |=> wd_window_sw_o == ($past(cfg.ws) >= WS_OPEN_ALT))
        else $error("window permission flag wrong");
    a_no_sw_before: assert property (clk_en_i && !cfg.valid |=> !wd_window_sw_o)
        else $error("window permission shown before load");
    a_window_out: assert property (clk_en_i |=> wd_window_o == $past(win_r))
        else $error("window output does not follow control register");

    // =========================================================
    // period and readiness
    a_period_seed: assert property (clk_en_i && load_now
        |=> per_r == $past(cfg.ps))
        else $error("period not seeded from configuration");
    a_period_write: assert property (clk_en_i && loaded_r && wr_i && addr_i == OFF_CTRL
        |=> per_r == $past(wdata_i[CTL_PER_LSB+:5]))
        else $error("period write lost");
    a_period_out: assert property (clk_en_i |=> wd_period_o == $past(per_r))
        else $error("period output does not follow control register");
    a_ready_follows: assert property (clk_en_i |=> cfg_ready_o == $past(loaded_r))
        else $error("ready flag does not follow seeding");

    // =========================================================
    // word layout and readback
    a_field_positions: assert property (cfg.valid |-> cfg.cs == cfg.word[13:11]
        && cfg.ws == cfg.word[10:8] && cfg.en == cfg.word[6:5] && cfg.ps == cfg.word[4:0])
        else $error("configuration field positions wrong");
    a_unimp_readback: assert property (clk_en_i && cfg.valid && rd_i
        && addr_i == OFF_CFG |=> rdata_o[CFG_UNIMP_BIT])
        else $error("unimplemented bit read back as zero");
    a_blank_word: assert property (clk_en_i && cfg.valid && cfg.word == 14'h0fff
        |=> wd_clk_sel_o == CS_MEDIUM_OSC && wd_run_o && wd_window_sw_o && !wd_keyed_req_o)
        else $error("blank word decode wrong");

    // =========================================================
    // main scenarios
    c_load: cover property (load_now);
    c_sleep_stop: cover property (cfg.en == EN_RUN_ONLY && sleep_i ##1 !wd_run_o);
    c_window_write: cover property (wr_i && addr_i == OFF_CTRL && win_sw_ok && loaded_r);
    c_reserved_clock: cover property (csres_r);
    c_soft_run: cover property (cfg.en == EN_SOFT && wd_run_o);
endmodule : wcd_top

// File: verilog/wcd_pkg.sv
// Purpose: constants for the watchdog configuration word decoder
// Assumes: 14-bit configuration word, 16-bit register port
// Notes: all offsets, field positions and control register reset values live here
package wcd_pkg;
    // =========================================================
    // configuration word layout
    localparam int CFG_W = 14;
    localparam int CFG_CS_LSB = 11;
    localparam int CFG_WS_LSB = 8;
    localparam int CFG_UNIMP_BIT = 7;
    localparam int CFG_EN_LSB = 5;
    localparam int CFG_PS_LSB = 0;
    // =========================================================
    // field encodings
    localparam logic [2:0] CS_RUNTIME = 3'h7;
    localparam logic [2:0] CS_MEDIUM_OSC = 3'h1;
    localparam logic [2:0] CS_LOW_OSC = 3'h0;
    localparam logic [2:0] WS_OPEN = 3'h7;
    localparam logic [2:0] WS_OPEN_ALT = 3'h6;
    localparam logic [1:0] EN_ALWAYS = 2'h3;
    localparam logic [1:0] EN_RUN_ONLY = 2'h2;
    localparam logic [1:0] EN_SOFT = 2'h1;
    localparam logic [1:0] EN_OFF = 2'h0;
    localparam int MEDIUM_OSC_HZ = 31250;
    localparam int LOW_OSC_HZ = 31000;
    // =========================================================
    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_CFG = 4'h1;
    localparam logic [3:0] OFF_STAT = 4'h2;
    // control register fields
    localparam int CTL_SEN_BIT = 0;
    localparam int CTL_PER_LSB = 1;
    localparam int CTL_CS_LSB = 8;
    localparam int CTL_WIN_LSB = 12;
    localparam logic CTL_SEN_RST = 1'h0;
    localparam logic [4:0] CTL_PER_RST = 5'h1f;
    localparam logic [2:0] CTL_CS_RST = 3'h0;
    localparam logic [2:0] CTL_WIN_RST = 3'h7;
    // status register fields
    localparam int ST_RUN_BIT = 0;
    localparam int ST_CLK_LSB = 1;
    localparam int ST_KEY_BIT = 4;
    localparam int ST_WSW_BIT = 5;
    localparam int ST_RDY_BIT = 6;
    localparam int ST_CSRES_BIT = 7;
    // =========================================================
    typedef enum logic [1:0] {
        LD_SYNC1 = 2'b00,
        LD_SYNC2 = 2'b01,
        LD_CAPT = 2'b11,
        LD_DONE = 2'b10
    } wcd_load_t;
endpackage : wcd_pkg

// File: verilog/wcd_cfg_if.sv
// Purpose: decoded configuration fields from loader to decoder core
// Assumes: single clock domain
// Notes: valid rises once after reset and then stays high
`timescale 1ns/10ps
interface wcd_cfg_if;
    logic valid;
    logic [13:0] word;
    logic [2:0] cs;
    logic [2:0] ws;
    logic [1:0] en;
    logic [4:0] ps;
    modport src (output valid, output word, output cs, output ws, output en, output ps);
    modport dst (input valid, input word, input cs, input ws, input en, input ps);
endinterface : wcd_cfg_if

// File: verilog/wcd_cfg_load.sv
// Purpose: synchronise and capture the nonvolatile configuration word
// Assumes: word is static while the device runs
// Notes: fields are valid from the third enabled edge after reset release
`timescale 1ns/10ps
module wcd_cfg_load
    import wcd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic [CFG_W-1:0] cfg_word_i,
    wcd_cfg_if.src cfg
);
    logic [CFG_W-1:0] sync1_r;
    logic [CFG_W-1:0] sync2_r;
    logic [CFG_W-1:0] word_r;
    logic [CFG_W-1:0] word_nxt;
    wcd_load_t st_r;
    wcd_load_t st_nxt;

    // =========================================================
    // two-stage synchroniser
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else if (clk_en_i)
        begin
            sync1_r <= cfg_word_i;
            sync2_r <= sync1_r;
        end
    end

    // =========================================================
    // load sequence
    always_comb
    begin
        st_nxt = st_r;
        word_nxt = word_r;
        case (st_r)
            LD_SYNC1: st_nxt = LD_SYNC2;
            LD_SYNC2: st_nxt = LD_CAPT;
            // the word reaches word_r only one edge after the second flop holds it
            LD_CAPT: st_nxt = LD_DONE;
            LD_DONE: st_nxt = LD_DONE;
            default: st_nxt = LD_SYNC1;
        endcase
        if (st_r != LD_SYNC1)
        begin
            word_nxt = sync2_r;
            word_nxt[CFG_UNIMP_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_r <= LD_SYNC1;
            word_r <= '0;
        end
        else if (clk_en_i)
        begin
            st_r <= st_nxt;
            word_r <= word_nxt;
        end
    end

    // field extraction
    assign cfg.valid = (st_r == LD_DONE);
    assign cfg.word = word_r;
    assign cfg.cs = word_r[CFG_CS_LSB+:3];
    assign cfg.ws = word_r[CFG_WS_LSB+:3];
    assign cfg.en = word_r[CFG_EN_LSB+:2];
    assign cfg.ps = word_r[CFG_PS_LSB+:5];

    a_unimp_reads_one: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cfg.valid |-> cfg.word[CFG_UNIMP_BIT])
        else $error("unimplemented config bit read as zero");
endmodule : wcd_cfg_load

// File: dv/tb.sv
// Purpose: self-checking bench for the watchdog configuration word decoder
// Assumes: clk_en_i held high except for one write; the configuration word changes only under reset
// Notes: eight words reach every clock, window and enable code, plus the blank word
`timescale 1ns/10ps
module tb;
    import wcd_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [CFG_W-1:0] cfg_word_i = 14'h0fff;
    logic sleep_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = 4'h0;
    logic [DATA_W-1:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic wd_run_o;
    logic [2:0] wd_clk_sel_o;
    logic [2:0] wd_window_o;
    logic [4:0] wd_period_o;
    logic wd_keyed_req_o;
    logic wd_window_sw_o;
    logic cfg_ready_o;
    int err_total = 0;
    int compares = 0;

    always #4 clk_i = ~clk_i;

    wcd_top i_wcd_top (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .cfg_word_i(cfg_word_i),
        .sleep_i(sleep_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .wd_run_o(wd_run_o),
        .wd_clk_sel_o(wd_clk_sel_o),
        .wd_window_o(wd_window_o),
        .wd_period_o(wd_period_o),
        .wd_keyed_req_o(wd_keyed_req_o),
        .wd_window_sw_o(wd_window_sw_o),
        .cfg_ready_o(cfg_ready_o)
    );

    // =========================================================
    // reporting
    task automatic summarize;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // =========================================================
    // register port
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : settle

    task automatic bus_wr(input logic [3:0] addr, input logic [15:0] data);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= addr;
        wdata_i <= data;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : bus_wr

    // data is taken in the one cycle after the strobe
    task automatic rd_chk(input string name, input logic [3:0] addr,
                          input logic [15:0] exp, input logic [15:0] mask);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= addr;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(name, exp & mask, rdata_o & mask);
    endtask : rd_chk

    task automatic load(input logic [13:0] word);
        int n;
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        sleep_i <= 1'b0;
        cfg_word_i <= word;
        settle(5);
        chk("run_in_reset", 16'h0000, {15'h0000, wd_run_o});
        chk("ready_in_reset", 16'h0000, {15'h0000, cfg_ready_o});
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        n = 0;
        while (cfg_ready_o !== 1'b1 && n < 20)
        begin
            @(negedge clk_i);
            n++;
        end
        if (cfg_ready_o !== 1'b1)
        begin
            err_total++;
            $display("mismatch cfg_ready expected 1 seen %b", cfg_ready_o);
            summarize();
        end
        settle(2);
    endtask : load

    // =========================================================
    // scenarios
    initial
    begin
        logic [13:0] word;
        logic [2:0] cs;
        logic [2:0] ws;
        logic [1:0] en;
        logic [4:0] ps;
        logic [2:0] e_cs;
        logic [2:0] e_win;
        logic keyed;
        logic rsv;
        // blank word, then refused accesses
        load(14'h0fff);
        chk("blank_clk", 16'h0001, {13'h0000, wd_clk_sel_o});
        chk("blank_win", 16'h0007, {13'h0000, wd_window_o});
        chk("blank_per", 16'h001f, {11'h000, wd_period_o});
        chk("blank_run", 16'h0001, {15'h0000, wd_run_o});
        // a write with the clock enable low must leave the seeded register alone
        @(posedge clk_i);
        clk_en_i <= 1'b0;
        bus_wr(OFF_CTRL, 16'h0000);
        clk_en_i <= 1'b1;
        rd_chk("ctrl_frozen", OFF_CTRL, 16'h703e, 16'hffff);
        bus_wr(OFF_CFG, 16'h0000);
        rd_chk("cfg_kept", OFF_CFG, 16'h0fff, 16'hffff);
        rd_chk("unmapped", 4'h3, 16'h0000, 16'hffff);
        settle(0);
        chk("rdata_idle", 16'h0000, rdata_o);
        for (int i = 0; i < 8; i++)
        begin
            cs = i[2:0];
            ws = 3'h7 - i[2:0];
            en = i[1:0];
            ps = 5'h03 + {i[2:0], 2'h0};
            word = {cs, ws, 1'h0, en, ps};
            e_cs = (cs == 3'h0 || cs == 3'h7) ? 3'h0 : 3'h1;
            rsv = (cs != 3'h0 && cs != 3'h1 && cs != 3'h7);
            keyed = (ws < 3'h6);
            e_win = keyed ? ws : 3'h7;
            load(word);
            chk("clk_sel", {13'h0000, e_cs}, {13'h0000, wd_clk_sel_o});
            chk("window", {13'h0000, e_win}, {13'h0000, wd_window_o});
            chk("keyed", {15'h0000, keyed}, {15'h0000, wd_keyed_req_o});
            chk("win_sw", {15'h0000, ~keyed}, {15'h0000, wd_window_sw_o});
            chk("period", {11'h000, ps}, {11'h000, wd_period_o});
            chk("run", {15'h0000, en[1]}, {15'h0000, wd_run_o});
            rd_chk("cfg", OFF_CFG, {2'h0, word | 14'h0080}, 16'hffff);
            rd_chk("stat", OFF_STAT, {8'h00, rsv, 1'h1, ~keyed, keyed, e_cs, en[1]},
                   16'h00ff);
            rd_chk("ctrl", OFF_CTRL, {1'h0, e_win, 4'h0, 2'h0, ps, 1'h0},
                   16'h773f);
            // sleep with the override clear, then set the override while asleep
            @(posedge clk_i);
            sleep_i <= 1'b1;
            settle(3);
            chk("run_sleep", {15'h0000, en == 2'h3}, {15'h0000, wd_run_o});
            bus_wr(OFF_CTRL, {1'h0, 3'h2, 1'h0, 3'h5, 2'h0, ~ps, 1'h1});
            settle(3);
            chk("run_sleep_sen", {15'h0000, en == 2'h3 || en == 2'h1},
                {15'h0000, wd_run_o});
            @(posedge clk_i);
            sleep_i <= 1'b0;
            settle(3);
            chk("run_wake_sen", {15'h0000, en != 2'h0}, {15'h0000, wd_run_o});
            chk("win_write", {13'h0000, keyed ? e_win : 3'h2},
                {13'h0000, wd_window_o});
            chk("clk_runtime", {13'h0000, cs == 3'h7 ? 3'h5 : e_cs},
                {13'h0000, wd_clk_sel_o});
            chk("per_write", {11'h000, ~ps}, {11'h000, wd_period_o});
        end
        summarize();
    end
endmodule : tb
